// ---- hw/rsp_pkg.sv ----
/*
 * rsp_pkg: constants, enumerations and carriers of the sweep sequencer.
 * assumes a 100 MHz mclk and frequencies expressed in hertz.
 */
package rsp_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned RAMP_UNIT_NS = 1_000_000;
  localparam int unsigned MS_CYCLES = RAMP_UNIT_NS / CLK_PERIOD_NS;

  localparam logic [16:0] RAMP_MS_MIN = 17'h00001;
  localparam logic [16:0] RAMP_MS_MAX = 17'h10000;
  localparam logic [8:0] REF_DIV_MIN = 9'h001;
  localparam logic [8:0] REF_DIV_MAX = 9'h100;
  // ref squared (20 MHz * 20) times hertz per gigahertz
  localparam logic [63:0] REF_MHZ = 64'h0000_0000_0000_0014;
  localparam logic [63:0] HZ_PER_GHZ = 64'h0000_0000_3B9A_CA00;
  localparam logic [63:0] RAMP_SCALE = REF_MHZ * REF_MHZ * HZ_PER_GHZ;
  localparam int unsigned PLL_FRAC_BITS = 25;

  localparam logic [31:0] FREQ_RST = 32'h0000_0000;
  localparam logic [31:0] TICK_RST = 32'h0000_0000;
  localparam logic [16:0] CNT_RST = 17'h00000;

  typedef enum logic [1:0] {
    PRF_RAMP, PRF_TRIANGLE, PRF_AUTO_TRIANGLE, PRF_FIXED_TONE
  } rsp_profile_e;

  typedef enum logic [1:0] {CMD_CONFIG, CMD_TRIGGER, CMD_STOP, CMD_MUTE} rsp_op_e;

  typedef enum logic [1:0] {PH_IDLE, PH_UP, PH_DOWN, PH_TONE} rsp_phase_e;

  typedef struct packed {
    logic valid;
    rsp_op_e op;
    logic [31:0] start_hz;
    logic [31:0] stop_hz;
    rsp_profile_e profile;
    logic [16:0] ramp_ms;
    logic [8:0] ref_div;
    logic mute_on;
  } rsp_cmd_s;

  typedef struct packed {
    logic [31:0] freq_hz;
    logic [8:0] pll_reference_divider;
    logic transmit_mute;
  } rsp_synth_s;

  typedef struct packed {
    rsp_phase_e phase;
    rsp_profile_e profile;
    logic [31:0] start_hz;
    logic [31:0] stop_hz;
    logic [16:0] ramp_ms;
    logic [8:0] ref_div;
    logic [31:0] step_hz;
    logic [31:0] freq_hz;
    logic [16:0] ms_cnt;
    logic [31:0] tick_cnt;
    logic mute;
    logic cfg_err;
  } rsp_state_s;

  localparam rsp_state_s STATE_RST = '{
    phase: PH_IDLE, profile: PRF_RAMP, start_hz: FREQ_RST,
    stop_hz: FREQ_RST, ramp_ms: RAMP_MS_MIN, ref_div: REF_DIV_MIN,
    step_hz: FREQ_RST, freq_hz: FREQ_RST, ms_cnt: CNT_RST,
    tick_cnt: TICK_RST, mute: 1'b1, cfg_err: 1'b0};

endpackage : rsp_pkg

// ---- hw/rsp_sweep_sequencer.sv ----
/*
 * rsp_sweep_sequencer: transmit sweep sequencer that steers a pll
 * synthesizer through ramp, triangle, auto triangle and fixed tone.
 * assumes both command links hold a command until they see ready and
 * that the synthesizer follows freq_hz on every clock.
 */
`timescale 1ns/1ns

module rsp_sweep_sequencer
  import rsp_pkg::*;
#(
  parameter int unsigned MS_TICKS = MS_CYCLES
)(
  input wire logic mclk,
  input wire logic rst,
  input wire rsp_cmd_s usb_cmd,
  output logic usb_ready,
  input wire rsp_cmd_s radio_cmd,
  output logic radio_ready,
  input wire logic hw_trigger,
  output rsp_synth_s synth,
  output logic sweep_active,
  output logic cfg_rejected
);

  if (MS_TICKS < 1) begin : g_bad_ticks
    $error("MS_TICKS must be at least one");
  end

  localparam logic [31:0] TICK_LAST = 32'(MS_TICKS - 1);

  rsp_state_s st_r;
  rsp_state_s st_nxt;
  rsp_cmd_s cmd;
  logic tick;
  logic last_ms;
  logic cfg_ok;
  // wide enough for a full 32-bit span times the largest divider code
  logic [67:0] need;
  logic [67:0] avail;
  logic [31:0] span;

  function automatic logic in_range(input logic [16:0] v,
                                    input logic [16:0] lo,
                                    input logic [16:0] hi);
    begin
      in_range = (v >= lo) && (v <= hi);
    end
  endfunction : in_range

  always_comb
  begin
    usb_ready = 1'b1;
    radio_ready = !usb_cmd.valid;
    cmd = usb_cmd.valid ? usb_cmd : radio_cmd;
  end

  always_comb
  begin
    span = cmd.stop_hz - cmd.start_hz;
    need = 68'(cmd.ramp_ms) * 68'(RAMP_SCALE);
    avail = (68'(span) * 68'(cmd.ref_div)) << PLL_FRAC_BITS;
  end

  always_comb
  begin
    cfg_ok = in_range(cmd.ramp_ms, RAMP_MS_MIN, RAMP_MS_MAX)
      && in_range({8'h00, cmd.ref_div}, {8'h00, REF_DIV_MIN},
                  {8'h00, REF_DIV_MAX});
    // step floor holds when span covers the ramp
    if (cmd.profile != PRF_FIXED_TONE)
    begin
      cfg_ok = cfg_ok && (cmd.stop_hz > cmd.start_hz) && (need <= avail);
    end
  end

  always_comb
  begin
    st_nxt = st_r;
    tick = 1'b0;
    last_ms = (st_r.ms_cnt + 17'h00001) >= st_r.ramp_ms;
    if ((st_r.phase == PH_UP) || (st_r.phase == PH_DOWN))
    begin
      if (st_r.tick_cnt == TICK_LAST)
      begin
        st_nxt.tick_cnt = TICK_RST;
        tick = 1'b1;
      end
      else
      begin
        st_nxt.tick_cnt = st_r.tick_cnt + 32'h0000_0001;
      end
    end
    else
    begin
      st_nxt.tick_cnt = TICK_RST;
    end
    // one step each ms, ramp_ms steps per leg
    if (tick)
    begin
      st_nxt.ms_cnt = st_r.ms_cnt + 17'h00001;
      if (st_r.phase == PH_UP)
      begin
        st_nxt.freq_hz = st_r.freq_hz + st_r.step_hz;
        if (last_ms)
        begin
          st_nxt.ms_cnt = CNT_RST;
          if (st_r.profile == PRF_RAMP)
          begin
            st_nxt.freq_hz = st_r.start_hz;
            st_nxt.phase = PH_IDLE;
          end
          else
          begin
            st_nxt.freq_hz = st_r.stop_hz;
            st_nxt.phase = PH_DOWN;
          end
        end
      end
      else
      begin
        st_nxt.freq_hz = st_r.freq_hz - st_r.step_hz;
        if (last_ms)
        begin
          st_nxt.ms_cnt = CNT_RST;
          st_nxt.freq_hz = st_r.start_hz;
          st_nxt.phase = (st_r.profile == PRF_AUTO_TRIANGLE) ? PH_UP
                                                              : PH_IDLE;
        end
      end
    end
    // commands override the sweep in the same cycle
    if (cmd.valid)
    begin
      case (cmd.op)
        CMD_CONFIG:
        begin
          st_nxt.cfg_err = !cfg_ok;
          if (cfg_ok)
          begin
            st_nxt.profile = cmd.profile;
            st_nxt.start_hz = cmd.start_hz;
            st_nxt.stop_hz = cmd.stop_hz;
            st_nxt.ramp_ms = cmd.ramp_ms;
            st_nxt.ref_div = cmd.ref_div;
            st_nxt.step_hz = span / 32'(cmd.ramp_ms);
            st_nxt.freq_hz = cmd.start_hz;
            st_nxt.ms_cnt = CNT_RST;
            st_nxt.tick_cnt = TICK_RST;
            // tone parks on start for good
            case (cmd.profile)
              PRF_FIXED_TONE: st_nxt.phase = PH_TONE;
              PRF_AUTO_TRIANGLE: st_nxt.phase = PH_UP;
              default: st_nxt.phase = PH_IDLE;
            endcase
          end
        end
        CMD_TRIGGER:
        begin
          if ((st_r.phase == PH_IDLE) && (st_r.profile != PRF_FIXED_TONE))
          begin
            st_nxt.phase = PH_UP;
          end
        end
        CMD_STOP:
        begin
          if (st_r.profile != PRF_FIXED_TONE)
          begin
            st_nxt.phase = PH_IDLE;
            st_nxt.freq_hz = st_r.start_hz;
            st_nxt.ms_cnt = CNT_RST;
          end
        end
        default:
        begin
          st_nxt.mute = cmd.mute_on;
        end
      endcase
    end
    // hardware trigger starts a waiting sweep
    else if (hw_trigger && (st_r.phase == PH_IDLE)
             && (st_r.profile != PRF_FIXED_TONE))
    begin
      st_nxt.phase = PH_UP;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_r <= STATE_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  always_comb
  begin
    synth.freq_hz = st_r.freq_hz;
    synth.pll_reference_divider = st_r.ref_div;
    synth.transmit_mute = st_r.mute;
    sweep_active = (st_r.phase == PH_UP) || (st_r.phase == PH_DOWN);
    cfg_rejected = st_r.cfg_err;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_tone_holds_start: assert property (
    st_r.phase == PH_TONE && !cmd.valid |=> st_r.freq_hz == st_r.start_hz
      && $stable(st_r.freq_hz))
    else $error("fixed tone moved off start");
  a_ramp_end_park: assert property (
    st_r.phase == PH_UP && st_r.profile == PRF_RAMP && tick && last_ms
      && !cmd.valid |=> st_r.phase == PH_IDLE
      && st_r.freq_hz == st_r.start_hz)
    else $error("ramp did not park at start");
  a_tri_turns_down: assert property (
    st_r.phase == PH_UP && st_r.profile == PRF_TRIANGLE && tick && last_ms
      && !cmd.valid |=> st_r.phase == PH_DOWN
      && st_r.freq_hz == st_r.stop_hz)
    else $error("triangle missed its top");
  a_auto_repeats: assert property (
    st_r.phase == PH_DOWN && st_r.profile == PRF_AUTO_TRIANGLE && tick
      && last_ms && !cmd.valid |=> st_r.phase == PH_UP)
    else $error("auto triangle did not repeat");
  a_stop_parks: assert property (
    cmd.valid && cmd.op == CMD_STOP && st_r.profile != PRF_FIXED_TONE
      |=> st_r.phase == PH_IDLE && st_r.freq_hz == $past(st_r.start_hz))
    else $error("stop did not park");
  a_cfg_ranges: assert property (
    $changed(st_r.ramp_ms) || $changed(st_r.ref_div) |->
      st_r.ramp_ms >= RAMP_MS_MIN && st_r.ramp_ms <= RAMP_MS_MAX
      && st_r.ref_div >= REF_DIV_MIN && st_r.ref_div <= REF_DIV_MAX)
    else $error("setting out of range");
  a_limit_rejects: assert property (
    cmd.valid && cmd.op == CMD_CONFIG && cmd.profile != PRF_FIXED_TONE
      && need > avail |=> cfg_rejected && $stable(st_r.ramp_ms))
    else $error("overlong ramp accepted");
  a_mute_follows: assert property (
    cmd.valid && cmd.op == CMD_MUTE |=> synth.transmit_mute
      == $past(cmd.mute_on))
    else $error("mute not applied");
  a_radio_waits: assert property (
    usb_cmd.valid && radio_cmd.valid && usb_cmd.op == CMD_MUTE
      |-> !radio_ready ##1 synth.transmit_mute == $past(usb_cmd.mute_on))
    else $error("wireless link not held off");
  a_trigger_starts: assert property (
    hw_trigger && !cmd.valid && st_r.phase == PH_IDLE
      && st_r.profile != PRF_FIXED_TONE |=> sweep_active)
    else $error("trigger ignored");

endmodule : rsp_sweep_sequencer

// ---- testbench/rsp_synth_model.sv ----
/*
 * rsp_synth_model: behavioural pll synthesizer fed by the sequencer.
 * assumes synth is registered on mclk and settles between edges.
 */
`timescale 1ns/1ns
module rsp_synth_model
  import rsp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire rsp_synth_s synth,
  output logic [31:0] rf_hz,
  output logic div_bad
);
  // locks one edge late, like a real loop settling
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rf_hz <= 32'h0000_0000;
      div_bad <= 1'b0;
    end
    else
    begin
      rf_hz <= synth.transmit_mute ? 32'h0000_0000 : synth.freq_hz;
      div_bad <= (synth.pll_reference_divider < REF_DIV_MIN) ||
                 (synth.pll_reference_divider > REF_DIV_MAX);
    end
  end
endmodule : rsp_synth_model

// ---- testbench/tb_radar_sweep_profile_sequencer.sv ----
/*
 * tb_radar_sweep_profile_sequencer: directed test of the sweep sequencer.
 * assumes a shortened millisecond tick and the pll model beside it.
 */
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_radar_sweep_profile_sequencer
  import rsp_pkg::*;
;
  localparam int unsigned TICKS = 4;
  localparam logic [31:0] F_LO = 32'h0000_03E8;
  localparam logic [31:0] F_HI = 32'h0000_07D0;
  localparam logic [31:0] F_STEP = 32'h0000_00FA;
  localparam logic [31:0] F_TONE = 32'h0000_0BB8;
  localparam logic [31:0] F_WIDE = 32'h003D_0CE8;
  localparam logic [16:0] MS4 = 17'h00004;
  localparam logic [8:0] DIV48 = 9'h030;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic hw_trigger = 1'b0;
  rsp_cmd_s usb_cmd = '0;
  rsp_cmd_s radio_cmd = '0;
  logic usb_ready;
  logic radio_ready;
  logic sweep_active;
  logic cfg_rejected;
  rsp_synth_s synth;
  logic [31:0] rf_hz;
  logic div_bad;
  int error_cnt = 0;
  int checks = 0;
  int n;
  // refused: ramp 0, ramp 65537, div 0, div 257, div 47 too short, flat
  logic [16:0] bad_ms [6] = '{17'h0, 17'h10001, MS4, MS4, MS4, MS4};
  logic [8:0] bad_div [6] = '{DIV48, 9'h100, 9'h0, 9'h101, 9'h02F, DIV48};
  logic [31:0] bad_hi [6] = '{F_HI, F_WIDE, F_HI, F_HI, F_HI, F_LO};

  rsp_sweep_sequencer #(.MS_TICKS(TICKS)) u_dut (.mclk, .rst, .usb_cmd,
    .usb_ready, .radio_cmd, .radio_ready, .hw_trigger, .synth,
    .sweep_active, .cfg_rejected);
  rsp_synth_model u_pll (.mclk, .rst, .synth, .rf_hz, .div_bad);

  initial forever #5 mclk = ~mclk;

  function automatic rsp_cmd_s mk(rsp_op_e op, logic [31:0] a,
    logic [31:0] b, rsp_profile_e p, logic [16:0] r, logic [8:0] d,
    logic m = 1'b0);
    mk = '{1'b1, op, a, b, p, r, d, m};
  endfunction : mk

  function automatic rsp_cmd_s op_only(rsp_op_e op, logic m = 1'b0);
    op_only = mk(op, F_LO, F_HI, PRF_RAMP, MS4, DIV48, m);
  endfunction : op_only

  // request held until ready is seen at a rising edge
  task automatic send(input logic radio, input rsp_cmd_s c);
    @(posedge mclk);
    #1;
    if (radio)
      radio_cmd = c;
    else
      usb_cmd = c;
    @(posedge mclk);
    while ((radio ? radio_ready : usb_ready) !== 1'b1)
      @(posedge mclk);
    #1;
    usb_cmd.valid = 1'b0;
    radio_cmd.valid = 1'b0;
  endtask : send

  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : tick

  task automatic wait_hz(input logic [31:0] f);
    n = 0;
    while (synth.freq_hz !== f && n < 300)
    begin
      tick(1);
      n++;
    end
    `CHK(synth.freq_hz, f)
  endtask : wait_hz

  task automatic wait_act(input logic a);
    n = 0;
    while (sweep_active !== a && n < 300)
    begin
      tick(1);
      n++;
    end
    `CHK(sweep_active, a)
  endtask : wait_act

  task automatic stop_test;
    if (error_cnt == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  // whole run is a few hundred cycles
  initial
  begin
    #20000;
    error_cnt++;
    stop_test();
  end

  initial
  begin
    tick(5);
    rst = 1'b0;
    `CHK(synth, {32'h0, 9'h001, 1'b1})
    `CHK({sweep_active, cfg_rejected}, 2'b00)
    for (int i = 0; i < 6; i++)
    begin
      send(1'b0, mk(CMD_CONFIG, F_LO, bad_hi[i], PRF_RAMP, bad_ms[i],
        bad_div[i]));
      `CHK(cfg_rejected, 1'b1)
      `CHK(synth.freq_hz, 32'h0)
    end
    send(1'b0, mk(CMD_CONFIG, F_LO, F_WIDE, PRF_RAMP, 17'h10000, 9'h100));
    `CHK({cfg_rejected, synth.freq_hz}, {1'b0, F_LO})
    send(1'b1, mk(CMD_CONFIG, F_LO, F_HI, PRF_RAMP, MS4, DIV48));
    `CHK(synth.pll_reference_divider, DIV48)
    `CHK(cfg_rejected, 1'b0)
    send(1'b1, op_only(CMD_TRIGGER));
    `CHK(sweep_active, 1'b1)
    wait_hz(F_LO + F_STEP);
    wait_act(1'b0);
    `CHK(synth.freq_hz, F_LO)
    send(1'b0, mk(CMD_CONFIG, F_LO, F_HI, PRF_TRIANGLE, MS4, DIV48));
    for (int k = 0; k < 2; k++)
    begin
      tick(1);
      hw_trigger = 1'b1;
      tick(1);
      hw_trigger = 1'b0;
      wait_hz(F_HI);
      `CHK(n, 4 * TICKS)
      wait_hz(F_HI - F_STEP);
      wait_act(1'b0);
      `CHK(synth.freq_hz, F_LO)
    end
    send(1'b0, mk(CMD_CONFIG, F_LO, F_HI, PRF_AUTO_TRIANGLE, MS4, DIV48));
    wait_hz(F_HI);
    wait_hz(F_LO);
    wait_hz(F_LO + F_STEP);
    `CHK(sweep_active, 1'b1)
    send(1'b1, op_only(CMD_STOP));
    `CHK({sweep_active, synth.freq_hz}, {1'b0, F_LO})
    tick(20);
    `CHK(synth.freq_hz, F_LO)
    send(1'b0, mk(CMD_CONFIG, F_TONE, 32'h0, PRF_FIXED_TONE, 17'h1, 9'h1));
    `CHK({cfg_rejected, synth.freq_hz}, {1'b0, F_TONE})
    send(1'b1, op_only(CMD_TRIGGER));
    tick(10);
    `CHK({sweep_active, synth.freq_hz}, {1'b0, F_TONE})
    for (int k = 0; k < 2; k++)
    begin
      send(!k[0], op_only(CMD_MUTE, k[0]));
      `CHK(synth.transmit_mute, k[0])
      tick(1);
      `CHK(rf_hz, k[0] ? 32'h0 : F_TONE)
    end
    // both links at once: usb taken first, wireless held until free
    @(posedge mclk);
    #1;
    usb_cmd = op_only(CMD_MUTE, 1'b0);
    radio_cmd = op_only(CMD_MUTE, 1'b1);
    @(negedge mclk);
    `CHK({usb_ready, radio_ready}, 2'b10)
    tick(1);
    usb_cmd.valid = 1'b0;
    `CHK(synth.transmit_mute, 1'b0)
    @(negedge mclk);
    `CHK(radio_ready, 1'b1)
    tick(1);
    radio_cmd.valid = 1'b0;
    `CHK(synth.transmit_mute, 1'b1)
    // reset in mid-run returns the idle, muted state
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    `CHK(synth, {32'h0, 9'h001, 1'b1})
    `CHK({sweep_active, cfg_rejected}, 2'b00)
    `CHK(div_bad, 1'b0)
    stop_test();
  end
endmodule : tb_radar_sweep_profile_sequencer
